// *** design/hdlc_axil_slave.sv ***
`timescale 1ns/1ps
module hdlc_axil_slave
  import hdlc_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic [31:0]       awaddr_i,
  input  wire logic              awvalid_i,
  output logic                   awready_o,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic [STRB_W-1:0] wstrb_i,
  input  wire logic              wvalid_i,
  output logic                   wready_o,
  output logic [1:0]             bresp_o,
  output logic                   bvalid_o,
  input  wire logic              bready_i,
  input  wire logic [31:0]       araddr_i,
  input  wire logic              arvalid_i,
  output logic                   arready_o,
  output logic [DATA_W-1:0]      rdata_o,
  output logic [1:0]             rresp_o,
  output logic                   rvalid_o,
  input  wire logic              rready_i,
  hdlc_reg_if.bus                rb
);

  typedef struct packed {
    logic              aw_full;
    logic [ADDR_W-1:0] aw_addr;
    logic              w_full;
    logic [DATA_W-1:0] w_data;
    logic [STRB_W-1:0] w_strb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
  } axil_state_t;

  axil_state_t st;
  axil_state_t next_st;

  // Handshake readies straight from state
  assign awready_o = !st.aw_full && !st.bvalid;
  assign wready_o  = !st.w_full && !st.bvalid;
  assign arready_o = !st.rvalid;

  // Write fires once both halves are held; one write in flight at most
  assign rb.wr_en   = st.aw_full && st.w_full && !st.bvalid;
  assign rb.wr_addr = st.aw_addr;
  assign rb.wr_data = st.w_data;
  assign rb.wr_strb = st.w_strb;
  assign rb.rd_addr = araddr_i[ADDR_W-1:0];

  // Channel bookkeeping
  always_comb begin
    next_st = st;
    if (awvalid_i && awready_o) begin
      next_st.aw_full = 1'b1;
      next_st.aw_addr = awaddr_i[ADDR_W-1:0];
    end
    if (wvalid_i && wready_o) begin
      next_st.w_full = 1'b1;
      next_st.w_data = wdata_i;
      next_st.w_strb = wstrb_i;
    end
    if (rb.wr_en) begin
      next_st.aw_full = 1'b0;
      next_st.w_full  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = rb.wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (st.bvalid && bready_i) begin
      next_st.bvalid = 1'b0;
    end
    if (arvalid_i && arready_o) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = rb.rd_ok ? rb.rd_data : '0;
      next_st.rresp  = rb.rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (st.rvalid && rready_i) begin
      next_st.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign bvalid_o = st.bvalid;
  assign bresp_o  = st.bresp;
  assign rvalid_o = st.rvalid;
  assign rdata_o  = st.rdata;
  assign rresp_o  = st.rresp;

endmodule

// *** design/hdlc_pkg.sv ***
package hdlc_pkg;

  // Register bus geometry
  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 32;
  localparam int          STRB_W         = DATA_W / 8;

  // Register byte offsets
  localparam logic [7:0]  OFS_STATUS     = 8'h00;
  localparam logic [7:0]  OFS_CONTROL    = 8'h04;
  localparam logic [7:0]  OFS_ENABLE     = 8'h08;

  // Values after reset
  localparam logic [31:0] STATUS_RESET   = 32'h00000000;
  localparam logic [31:0] ENABLE_RESET   = 32'h00000000;
  localparam logic        CTL_BIT_RESET  = 1'b0;
  localparam logic        PIN_N_RESET    = 1'b1;
  localparam logic [7:0]  SHIFT_RESET    = 8'h00;
  localparam logic [3:0]  RUN_RESET      = 4'h0;

  // Status bit positions
  localparam int BIT_FLAG_SEEN      = 11;
  localparam int BIT_CARRIER_LEVEL  = 12;
  localparam int BIT_CARRIER_CHANGE = 13;
  localparam int BIT_FRAME_GOOD     = 14;
  localparam int BIT_LINE_IDLE      = 15;
  localparam int BIT_ABORT_SEEN     = 16;
  localparam int BIT_CHECK_FAIL     = 17;
  localparam int BIT_PARTIAL_OCTET  = 18;
  localparam int BIT_FIFO_OVERRUN   = 19;
  localparam int BIT_BUF_EXHAUSTED  = 20;
  localparam int BIT_TX_DMA_ABORTED = 22;
  localparam int BIT_CLK_UNSTABLE   = 23;
  localparam int BIT_RX_DMA_DONE    = 24;
  localparam int BIT_RX_DMA_NULL    = 25;
  localparam int BIT_RX_DMA_NOT_OWN = 26;
  localparam int BIT_TX_DMA_DONE    = 27;
  localparam int BIT_TX_DMA_NULL    = 28;
  localparam int BIT_TX_DMA_NOT_OWN = 29;
  localparam int BIT_DPLL_ONE_MISS  = 30;
  localparam int BIT_DPLL_TWO_MISS  = 31;

  // Sticky, write-one-to-clear and interrupt-capable bits
  localparam logic [31:0] STICKY_MASK    = 32'hffdfe800;

  // Control bit positions
  localparam int CTL_RX_DMA_EN      = 0;
  localparam int CTL_TX_DMA_EN      = 1;
  localparam int CTL_RX_STOP_SKIP   = 2;
  localparam int CTL_TX_STOP_SKIP   = 3;
  localparam int CTL_MULTI_FILL     = 4;
  localparam int CTL_DPLL_EN        = 5;
  localparam int CTL_FM_MODE        = 6;

  // Line pattern figures
  localparam logic [7:0]  FLAG_PATTERN   = 8'h7e;
  localparam logic [3:0]  RUN_ABORT_PRE  = 4'h6;
  localparam logic [3:0]  RUN_IDLE_PRE   = 4'he;
  localparam logic [3:0]  RUN_MAX        = 4'hf;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

endpackage

// *** design/hdlc_reg_if.sv ***
`timescale 1ns/1ps
interface hdlc_reg_if import hdlc_pkg::*; ();
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [STRB_W-1:0] wr_strb;
  logic              wr_ok;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic              rd_ok;

  modport bus (
    output wr_en,
    output wr_addr,
    output wr_data,
    output wr_strb,
    output rd_addr,
    input  wr_ok,
    input  rd_data,
    input  rd_ok
  );

  modport regs (
    input  wr_en,
    input  wr_addr,
    input  wr_data,
    input  wr_strb,
    input  rd_addr,
    output wr_ok,
    output rd_data,
    output rd_ok
  );
endinterface

// *** design/hdlc_rx_dma_status_flags.sv ***
`timescale 1ns/1ps
module hdlc_rx_dma_status_flags
  import hdlc_pkg::*;
(
  input  wire logic              CLK_I,
  input  wire logic              RST_I,
  // AXI4-Lite register port
  input  wire logic [31:0]       S_AXI_AWADDR_I,
  input  wire logic              S_AXI_AWVALID_I,
  output logic                   S_AXI_AWREADY_O,
  input  wire logic [DATA_W-1:0] S_AXI_WDATA_I,
  input  wire logic [STRB_W-1:0] S_AXI_WSTRB_I,
  input  wire logic              S_AXI_WVALID_I,
  output logic                   S_AXI_WREADY_O,
  output logic [1:0]             S_AXI_BRESP_O,
  output logic                   S_AXI_BVALID_O,
  input  wire logic              S_AXI_BREADY_I,
  input  wire logic [31:0]       S_AXI_ARADDR_I,
  input  wire logic              S_AXI_ARVALID_I,
  output logic                   S_AXI_ARREADY_O,
  output logic [DATA_W-1:0]      S_AXI_RDATA_O,
  output logic [1:0]             S_AXI_RRESP_O,
  output logic                   S_AXI_RVALID_O,
  input  wire logic              S_AXI_RREADY_I,
  // Carrier detect pin, active low, asynchronous
  input  wire logic              CARRIER_DETECT_N_I,
  // Receive bit stream after zero deletion logic
  input  wire logic              RX_BIT_VALID_I,
  input  wire logic              RX_BIT_I,
  // Receive frame results
  input  wire logic              RX_FRAME_END_I,
  input  wire logic              RX_CRC_ERR_I,
  input  wire logic              RX_PARTIAL_I,
  input  wire logic              RX_FIFO_WRITE_I,
  input  wire logic              RX_FIFO_FULL_I,
  input  wire logic              RX_CLOCK_UNSTABLE_I,
  // DMA outcomes
  input  wire logic              RX_NO_BUFFER_I,
  input  wire logic              RX_DMA_FRAME_DONE_I,
  input  wire logic              RX_DMA_NULL_I,
  input  wire logic              RX_DMA_NOT_OWNED_I,
  input  wire logic              TX_ABORT_SENT_I,
  input  wire logic              TX_FRAME_DONE_I,
  input  wire logic              TX_DMA_NULL_I,
  input  wire logic              TX_DMA_NOT_OWNED_I,
  // DPLL edge search results
  input  wire logic              DPLL_MISS_I,
  input  wire logic              DPLL_EDGE_I,
  // Control outputs
  output logic                   RX_DMA_ENABLE_O,
  output logic                   TX_DMA_ENABLE_O,
  output logic                   RX_STOP_ON_SKIP_O,
  output logic                   TX_STOP_ON_SKIP_O,
  output logic                   MULTI_FRAME_FILL_O,
  output logic                   DPLL_ENABLE_O,
  output logic                   FM_MODE_O,
  output logic                   RX_FIFO_FLUSH_O,
  output logic                   DPLL_SEARCH_O,
  output logic                   IRQ_O
);

  typedef struct packed {
    logic [31:0] sticky;
    logic [31:0] enable;
    logic        rx_dma_enable_bit;
    logic        tx_dma_enable_bit;
    logic        rx_stop_on_skip;
    logic        tx_stop_on_skip;
    logic        multi_frame_fill;
    logic        dpll_enable;
    logic        fm_mode;
    logic        carrier_prev;
    logic [7:0]  shift;
    logic [3:0]  ones_run;
    logic        miss_pending;
    logic        flush;
    logic        search;
    logic        irq;
  } flags_state_t;

  flags_state_t st;
  flags_state_t next_st;

  hdlc_reg_if rb ();

  logic              carrier_detect_n;
  logic [DATA_W-1:0] lane_mask;
  logic [31:0]       set_v;
  logic [31:0]       clr_v;
  logic [31:0]       status_view;
  logic [31:0]       next_view;
  logic [31:0]       control_view;
  logic [7:0]        next_shift;
  logic              dpll_active;
  logic              next_dpll_active;
  logic              line_idle;
  logic              next_line_idle;
  logic              wr_status;
  logic              wr_control;
  logic              wr_enable;

  // Bus slave carries accesses over the register interface
  hdlc_axil_slave u_axil (
    .clk_i     (CLK_I),
    .rst_i     (RST_I),
    .awaddr_i  (S_AXI_AWADDR_I),
    .awvalid_i (S_AXI_AWVALID_I),
    .awready_o (S_AXI_AWREADY_O),
    .wdata_i   (S_AXI_WDATA_I),
    .wstrb_i   (S_AXI_WSTRB_I),
    .wvalid_i  (S_AXI_WVALID_I),
    .wready_o  (S_AXI_WREADY_O),
    .bresp_o   (S_AXI_BRESP_O),
    .bvalid_o  (S_AXI_BVALID_O),
    .bready_i  (S_AXI_BREADY_I),
    .araddr_i  (S_AXI_ARADDR_I),
    .arvalid_i (S_AXI_ARVALID_I),
    .arready_o (S_AXI_ARREADY_O),
    .rdata_o   (S_AXI_RDATA_O),
    .rresp_o   (S_AXI_RRESP_O),
    .rvalid_o  (S_AXI_RVALID_O),
    .rready_i  (S_AXI_RREADY_I),
    .rb        (rb.bus)
  );

  // Pin comes from outside the clock domain
  hdlc_sync2 u_dcd_sync (
    .clk_i (CLK_I),
    .rst_i (RST_I),
    .d_i   (CARRIER_DETECT_N_I),
    .q_o   (carrier_detect_n)
  );

  // Byte lanes widened to bit masks
  for (genvar i = 0; i < STRB_W; i++) begin : g_lane
    assign lane_mask[8*i +: 8] = {8{rb.wr_strb[i]}};
  end

  // Address decode
  assign wr_status  = rb.wr_en && (rb.wr_addr == OFS_STATUS);
  assign wr_control = rb.wr_en && (rb.wr_addr == OFS_CONTROL);
  assign wr_enable  = rb.wr_en && (rb.wr_addr == OFS_ENABLE);
  assign rb.wr_ok   = (rb.wr_addr == OFS_STATUS) ||
                      (rb.wr_addr == OFS_CONTROL) ||
                      (rb.wr_addr == OFS_ENABLE);
  assign rb.rd_ok   = (rb.rd_addr == OFS_STATUS) ||
                      (rb.rd_addr == OFS_CONTROL) ||
                      (rb.rd_addr == OFS_ENABLE);

  // Two-miss only meaningful in FM or Manchester with DPLL running
  assign dpll_active = st.dpll_enable && st.fm_mode;
  assign line_idle   = (st.ones_run == RUN_MAX);

  // Live view of the status word
  always_comb begin
    status_view                    = st.sticky & STICKY_MASK;
    status_view[BIT_CARRIER_LEVEL] = !carrier_detect_n;
    status_view[BIT_LINE_IDLE]     = st.sticky[BIT_LINE_IDLE] ||
                                     line_idle;
    status_view[BIT_DPLL_TWO_MISS] = st.sticky[BIT_DPLL_TWO_MISS] &&
                                     dpll_active;
  end

  // Control word packed for reads
  always_comb begin
    control_view                   = '0;
    control_view[CTL_RX_DMA_EN]    = st.rx_dma_enable_bit;
    control_view[CTL_TX_DMA_EN]    = st.tx_dma_enable_bit;
    control_view[CTL_RX_STOP_SKIP] = st.rx_stop_on_skip;
    control_view[CTL_TX_STOP_SKIP] = st.tx_stop_on_skip;
    control_view[CTL_MULTI_FILL]   = st.multi_frame_fill;
    control_view[CTL_DPLL_EN]      = st.dpll_enable;
    control_view[CTL_FM_MODE]      = st.fm_mode;
  end

  // Read mux; reads have no side effects
  always_comb begin
    rb.rd_data = '0;
    if (rb.rd_addr == OFS_STATUS) begin
      rb.rd_data = status_view;
    end else if (rb.rd_addr == OFS_CONTROL) begin
      rb.rd_data = control_view;
    end else if (rb.rd_addr == OFS_ENABLE) begin
      rb.rd_data = st.enable;
    end
  end

  // Shift register view including the arriving bit
  assign next_shift = {st.shift[6:0], RX_BIT_I};

  // Hardware events for the sticky bits
  always_comb begin
    set_v = '0;
    if (RX_BIT_VALID_I) begin
      set_v[BIT_FLAG_SEEN]  = (next_shift == FLAG_PATTERN);
      set_v[BIT_ABORT_SEEN] = RX_BIT_I &&
                              (st.ones_run == RUN_ABORT_PRE);
      set_v[BIT_LINE_IDLE]  = RX_BIT_I &&
                              (st.ones_run == RUN_IDLE_PRE);
    end
    set_v[BIT_CARRIER_CHANGE] = carrier_detect_n != st.carrier_prev;
    set_v[BIT_FRAME_GOOD]     = RX_FRAME_END_I && !RX_CRC_ERR_I &&
                                !RX_PARTIAL_I;
    set_v[BIT_CHECK_FAIL]     = RX_FRAME_END_I && RX_CRC_ERR_I;
    set_v[BIT_PARTIAL_OCTET]  = RX_FRAME_END_I && RX_PARTIAL_I;
    set_v[BIT_FIFO_OVERRUN]   = RX_FIFO_WRITE_I && RX_FIFO_FULL_I;
    set_v[BIT_BUF_EXHAUSTED]  = RX_NO_BUFFER_I;
    set_v[BIT_TX_DMA_ABORTED] = TX_ABORT_SENT_I;
    set_v[BIT_CLK_UNSTABLE]   = RX_CLOCK_UNSTABLE_I;
    set_v[BIT_RX_DMA_DONE]    = RX_DMA_FRAME_DONE_I;
    set_v[BIT_RX_DMA_NULL]    = RX_DMA_NULL_I;
    set_v[BIT_RX_DMA_NOT_OWN] = RX_DMA_NOT_OWNED_I &&
                                st.rx_stop_on_skip;
    set_v[BIT_TX_DMA_DONE]    = TX_FRAME_DONE_I &&
                                !st.multi_frame_fill;
    set_v[BIT_TX_DMA_NULL]    = TX_DMA_NULL_I;
    set_v[BIT_TX_DMA_NOT_OWN] = TX_DMA_NOT_OWNED_I &&
                                st.tx_stop_on_skip;
    set_v[BIT_DPLL_ONE_MISS]  = dpll_active && DPLL_MISS_I &&
                                !st.miss_pending;
    set_v[BIT_DPLL_TWO_MISS]  = dpll_active && DPLL_MISS_I &&
                                st.miss_pending;
  end

  // Only ones written to sticky positions clear
  assign clr_v = wr_status ? (rb.wr_data & lane_mask & STICKY_MASK)
                           : '0;

  // Next state of the whole block
  always_comb begin
    next_st = st;

    // Set wins over a clear in the same cycle
    next_st.sticky = ((st.sticky & ~clr_v) | set_v) & STICKY_MASK;
    next_st.carrier_prev = carrier_detect_n;

    // Run of ones saturates so idle holds until a zero
    if (RX_BIT_VALID_I) begin
      next_st.shift = next_shift;
      if (!RX_BIT_I) begin
        next_st.ones_run = RUN_RESET;
      end else if (st.ones_run != RUN_MAX) begin
        next_st.ones_run = st.ones_run + 4'h1;
      end
    end

    // Software control writes, low byte lane only
    if (wr_control && rb.wr_strb[0]) begin
      next_st.rx_dma_enable_bit = rb.wr_data[CTL_RX_DMA_EN];
      next_st.tx_dma_enable_bit = rb.wr_data[CTL_TX_DMA_EN];
      next_st.rx_stop_on_skip   = rb.wr_data[CTL_RX_STOP_SKIP];
      next_st.tx_stop_on_skip   = rb.wr_data[CTL_TX_STOP_SKIP];
      next_st.multi_frame_fill  = rb.wr_data[CTL_MULTI_FILL];
      next_st.dpll_enable       = rb.wr_data[CTL_DPLL_EN];
      next_st.fm_mode           = rb.wr_data[CTL_FM_MODE];
    end
    if (wr_enable) begin
      next_st.enable = ((st.enable & ~lane_mask) |
                        (rb.wr_data & lane_mask)) & STICKY_MASK;
    end

    // Hardware disables override a same-cycle software enable
    if (set_v[BIT_BUF_EXHAUSTED]) begin
      next_st.rx_dma_enable_bit = 1'b0;
    end
    if (set_v[BIT_RX_DMA_NULL]) begin
      next_st.rx_dma_enable_bit = 1'b0;
    end
    if (set_v[BIT_RX_DMA_NOT_OWN]) begin
      next_st.rx_dma_enable_bit = 1'b0;
    end
    if (set_v[BIT_TX_DMA_ABORTED]) begin
      next_st.tx_dma_enable_bit = 1'b0;
    end
    if (set_v[BIT_TX_DMA_NULL]) begin
      next_st.tx_dma_enable_bit = 1'b0;
    end
    if (set_v[BIT_TX_DMA_NOT_OWN]) begin
      next_st.tx_dma_enable_bit = 1'b0;
    end

    // Flush pulse stops FIFO-to-memory moves and empties the FIFO
    next_st.flush = set_v[BIT_RX_DMA_NULL];

    // Miss tracking; a found edge or leaving FM mode starts over
    next_st.search = set_v[BIT_DPLL_TWO_MISS];
    if (!dpll_active || DPLL_EDGE_I) begin
      next_st.miss_pending = 1'b0;
    end else if (DPLL_MISS_I) begin
      next_st.miss_pending = !st.miss_pending;
    end

    // Status view after this edge; built here so no comb loop forms
    next_dpll_active             = next_st.dpll_enable && next_st.fm_mode;
    next_line_idle               = (next_st.ones_run == RUN_MAX);
    next_view                    = next_st.sticky;
    next_view[BIT_LINE_IDLE]     = next_st.sticky[BIT_LINE_IDLE] ||
                                   next_line_idle;
    next_view[BIT_DPLL_TWO_MISS] = next_st.sticky[BIT_DPLL_TWO_MISS] &&
                                   next_dpll_active;

    // Interrupt from the status view that the next cycle will show
    next_st.irq = |(next_view & next_st.enable & STICKY_MASK);
  end

  // State register
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      st                   <= '0;
      st.sticky            <= STATUS_RESET;
      st.enable            <= ENABLE_RESET;
      st.rx_dma_enable_bit <= CTL_BIT_RESET;
      st.tx_dma_enable_bit <= CTL_BIT_RESET;
      st.rx_stop_on_skip   <= CTL_BIT_RESET;
      st.tx_stop_on_skip   <= CTL_BIT_RESET;
      st.multi_frame_fill  <= CTL_BIT_RESET;
      st.dpll_enable       <= CTL_BIT_RESET;
      st.fm_mode           <= CTL_BIT_RESET;
      st.carrier_prev      <= PIN_N_RESET;
      st.shift             <= SHIFT_RESET;
      st.ones_run          <= RUN_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flip-flops
  assign RX_DMA_ENABLE_O    = st.rx_dma_enable_bit;
  assign TX_DMA_ENABLE_O    = st.tx_dma_enable_bit;
  assign RX_STOP_ON_SKIP_O  = st.rx_stop_on_skip;
  assign TX_STOP_ON_SKIP_O  = st.tx_stop_on_skip;
  assign MULTI_FRAME_FILL_O = st.multi_frame_fill;
  assign DPLL_ENABLE_O      = st.dpll_enable;
  assign FM_MODE_O          = st.fm_mode;
  assign RX_FIFO_FLUSH_O    = st.flush;
  assign DPLL_SEARCH_O      = st.search;
  assign IRQ_O              = st.irq;

endmodule

// *** design/hdlc_sync2.sv ***
`timescale 1ns/1ps
module hdlc_sync2
  import hdlc_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic d_i,
  output logic      q_o
);

  typedef struct packed {
    logic meta;
    logic sync;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  // First stage feeds only the second stage
  always_comb begin
    next_st      = st;
    next_st.meta = d_i;
    next_st.sync = st.meta;
  end

  // Resets to the inactive pin level so no false edge is seen
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= {PIN_N_RESET, PIN_N_RESET};
    end else begin
      st <= next_st;
    end
  end

  assign q_o = st.sync;

endmodule

// *** tb/hdlc_line_station.sv ***
`timescale 1ns/1ps
module hdlc_line_station (
  input  wire logic       clk_i,
  input  wire logic [7:0] octet_i,
  input  wire logic       send_i,
  output logic            bit_valid_o = 1'b0,
  output logic            bit_o = 1'b0,
  output logic            busy_o
);
  logic [7:0] sh = 8'h00;
  logic [3:0] n = 4'h0;
  assign busy_o = n != 4'h0;
  // One bit a clock, oldest first; line toggles between octets
  always @(posedge clk_i) begin
    bit_valid_o <= busy_o;
    bit_o <= busy_o ? sh[0] : ~bit_o;
    sh <= busy_o ? sh >> 1 : octet_i;
    n <= busy_o ? n - 4'h1 : (send_i ? 4'h8 : 4'h0);
  end
endmodule

// *** tb/hdlc_status_assertions.sv ***
`timescale 1ns/1ps
module hdlc_status_assertions (
  input wire logic CLK_I, RST_I, RX_DMA_NULL_I, RX_DMA_NOT_OWNED_I,
  input wire logic RX_NO_BUFFER_I, TX_ABORT_SENT_I, TX_DMA_NULL_I,
  input wire logic TX_DMA_NOT_OWNED_I, DPLL_MISS_I, RX_DMA_ENABLE_O,
  input wire logic TX_DMA_ENABLE_O, RX_STOP_ON_SKIP_O, TX_STOP_ON_SKIP_O,
  input wire logic RX_FIFO_FLUSH_O, DPLL_SEARCH_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  // Hardware disables win over a same-cycle enable write; flush and search pulses need a cause
  sequence rx_null_seen; RX_DMA_NULL_I; endsequence
  sequence rx_stopped; RX_FIFO_FLUSH_O && !RX_DMA_ENABLE_O; endsequence
  chk_rx_null_stop: assert property (rx_null_seen |=> rx_stopped)
    else $error("rx null not handled");
  chk_flush_cause: assert property (
    RX_FIFO_FLUSH_O |-> $past(RX_DMA_NULL_I))
    else $error("flush without cause");
  chk_tx_null_off: assert property (
    TX_DMA_NULL_I |=> !TX_DMA_ENABLE_O)
    else $error("tx null kept enable");
  chk_no_buf_off: assert property (
    RX_NO_BUFFER_I |=> !RX_DMA_ENABLE_O)
    else $error("rx enable kept");
  chk_tx_abort_off: assert property (
    TX_ABORT_SENT_I |=> !TX_DMA_ENABLE_O)
    else $error("tx enable kept");
  chk_search_cause: assert property (
    DPLL_SEARCH_O |-> $past(DPLL_MISS_I))
    else $error("search without miss");
  chk_rx_skip_off: assert property (
    RX_DMA_NOT_OWNED_I && RX_STOP_ON_SKIP_O |=> !RX_DMA_ENABLE_O)
    else $error("rx skip kept enable");
  chk_tx_skip_off: assert property (
    TX_DMA_NOT_OWNED_I && TX_STOP_ON_SKIP_O |=> !TX_DMA_ENABLE_O)
    else $error("tx skip kept enable");
endmodule
bind hdlc_rx_dma_status_flags hdlc_status_assertions chk_i (.*);

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
  import hdlc_pkg::*;
  logic CLK_I = 0, RST_I = 1, awv = 0, wv = 0, arv = 0, cd_n = 1, send = 0;
  logic [7:0] awa = 0, ara = 0, oct = 0;
  logic [15:0] ev = '0;
  logic [31:0] wd = 0, rdv, e, rdata;
  logic [1:0] resp, bresp, rresp;
  logic aw_r, w_r, b_v, ar_r, r_v, rxen, txen, bv, bd, busy, irq, srch;
  logic [6:2] ctl;
  int mismatches = 0, total_checks = 0, searches = 0;
  int pos [14] = '{14, 17, 18, 19, 0, 23, 20, 24, 25, 26, 22, 27, 28, 29};
  hdlc_rx_dma_status_flags hdlc_rx_dma_status_flags_i (.CLK_I(CLK_I),
    .RST_I(RST_I), .S_AXI_AWADDR_I({24'h0, awa}), .S_AXI_AWVALID_I(awv),
    .S_AXI_AWREADY_O(aw_r), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hf),
    .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(w_r), .S_AXI_BRESP_O(bresp),
    .S_AXI_BVALID_O(b_v), .S_AXI_BREADY_I(1'b1), .S_AXI_ARADDR_I({24'h0, ara}),
    .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(ar_r), .S_AXI_RDATA_O(rdata),
    .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(r_v), .S_AXI_RREADY_I(1'b1),
    .CARRIER_DETECT_N_I(cd_n), .RX_BIT_VALID_I(bv), .RX_BIT_I(bd),
    .RX_FRAME_END_I(ev[0]), .RX_CRC_ERR_I(ev[1]), .RX_PARTIAL_I(ev[2]),
    .RX_FIFO_FULL_I(ev[3]), .RX_FIFO_WRITE_I(ev[4]),
    .RX_CLOCK_UNSTABLE_I(ev[5]),
    .RX_NO_BUFFER_I(ev[6]), .RX_DMA_FRAME_DONE_I(ev[7]), .RX_DMA_NULL_I(ev[8]),
    .RX_DMA_NOT_OWNED_I(ev[9]), .TX_ABORT_SENT_I(ev[10]),
    .TX_FRAME_DONE_I(ev[11]), .TX_DMA_NULL_I(ev[12]),
    .TX_DMA_NOT_OWNED_I(ev[13]), .DPLL_MISS_I(ev[14]), .DPLL_EDGE_I(ev[15]),
    .RX_DMA_ENABLE_O(rxen), .TX_DMA_ENABLE_O(txen),
    .RX_STOP_ON_SKIP_O(ctl[2]), .TX_STOP_ON_SKIP_O(ctl[3]),
    .MULTI_FRAME_FILL_O(ctl[4]), .DPLL_ENABLE_O(ctl[5]), .FM_MODE_O(ctl[6]),
    .RX_FIFO_FLUSH_O(), .DPLL_SEARCH_O(srch), .IRQ_O(irq));
  hdlc_line_station hdlc_line_station_i (.clk_i(CLK_I), .octet_i(oct),
    .send_i(send), .bit_valid_o(bv), .bit_o(bd), .busy_o(busy));
  initial forever #50 CLK_I = ~CLK_I;
  // Counts restart pulses of the edge search
  always @(posedge CLK_I) begin
    if (srch) searches <= searches + 1;
  end
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] x);
    total_checks++;
    if (s !== x) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, s, x);
    end
  endtask
  // Bus tasks start just after an edge; the BREADY and RREADY lines are tied high
  task wr(input logic [7:0] a, input logic [31:0] d);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1;
    do begin
      @(posedge CLK_I);
      if (aw_r) awv <= 1'b0;
      if (w_r) wv <= 1'b0;
    end while (!b_v);
    resp = bresp;
  endtask
  task rd(input logic [7:0] a);
    ara <= a; arv <= 1'b1;
    do begin
      @(posedge CLK_I);
      if (ar_r) arv <= 1'b0;
    end while (!r_v);
    rdv = rdata; resp = rresp;
  endtask
  task rs(input logic [31:0] x); rd(OFS_STATUS); chk(rdv, x); endtask
  task pulse(input logic [15:0] p);
    ev <= p; @(posedge CLK_I); ev <= '0; @(posedge CLK_I);
  endtask
  task line(input logic [7:0] o);
    oct <= o; send <= 1'b1; @(posedge CLK_I); send <= 1'b0; @(posedge CLK_I);
    while (busy) @(posedge CLK_I);
    repeat (2) @(posedge CLK_I);
  endtask
  initial begin
    repeat (10) @(posedge CLK_I);
    RST_I <= 1'b0; @(posedge CLK_I);
    rs(STATUS_RESET);
    wr(OFS_ENABLE, '1);
    chk(32'(resp), 32'(RESP_OKAY));
    rd(OFS_ENABLE);
    chk(rdv, STICKY_MASK);
    wr(OFS_CONTROL, 32'h6f);
    rd(OFS_CONTROL);
    chk(rdv, 32'h6f);
    chk(32'({ctl, txen, rxen}), 32'h6f);
    line(8'h7e);
    rs(32'h800);
    wr(OFS_STATUS, 32'h0); rs(32'h800);
    wr(OFS_STATUS, 32'h800); rs(32'h0);
    line(8'hff); line(8'hff); rs(32'h18000);
    wr(OFS_STATUS, '1); rs(32'h8000);
    line(8'h7e); rs(32'h800);
    // Second pass drops skip stops and sets multi-frame fill
    for (int k = 0; k < 2; k++) for (int i = 0; i < 14; i++) begin
      wr(OFS_STATUS, '1); wr(OFS_CONTROL, k ? 32'h73 : 32'h6f);
      pulse(16'h1 << i | (i inside {1, 2}) | (i == 3 ? 16'h10 : 16'h0));
      e = (pos[i] && !(k && i inside {9, 11, 13})) ? 32'h1 << pos[i] : 32'h0;
      rs(e);
      chk(32'(irq), 32'(|e));
      chk(32'(rxen), 32'(!(i inside {6, 8} || i == 9 && !k)));
      chk(32'(txen), 32'(!(i inside {10, 12} || i == 13 && !k)));
    end
    wr(OFS_STATUS, '1); wr(OFS_CONTROL, 32'h6f); pulse(16'h4000);
    rs(32'h40000000); pulse(16'h4000); rs(32'hc0000000);
    // A found edge between two misses restarts the count
    wr(OFS_STATUS, '1);
    pulse(16'h4000);
    pulse(16'h8000);
    pulse(16'h4000);
    rs(32'h40000000);
    wr(OFS_STATUS, '1);
    wr(OFS_CONTROL, 32'h0f);
    pulse(16'h4000);
    pulse(16'h4000);
    rs(32'h0);
    chk(searches, 1);
    cd_n <= 1'b0; repeat (5) @(posedge CLK_I); rs(32'h3000);
    wr(8'h10, '1);
    chk(32'(resp), 32'(RESP_SLVERR));
    rd(8'h10);
    chk(rdv, 32'h0);
    chk(32'(resp), 32'(RESP_SLVERR));
    report_and_stop;
  end
  initial begin
    repeat (8000) @(posedge CLK_I);
    mismatches++;
    report_and_stop;
  end
endmodule
